/* File: hdl/peripheral_clock_gate_bank.sv */
// APB register bank that gates the clocks of seven peripherals and flags accesses to gated ones
//
// Behaviour
// R1: Gate bit one clocks peripheral, zero stops it
// R2: Access to gated peripheral answers bus fault
// R3: All gate bits clear after reset
// R4: Run, sleep, deep-sleep register picked by mode
// R5: Sleep registers apply only with auto gating
// R6: Bits 18..16 gate counters c, b, a
// R7: Bit 12 gates two-wire port
// R8: Bit 4 gates synchronous serial
// R9: Bits 1, 0 gate async ports b, a
// R10: Reserved bits read zero, ignore writes
// R11: Run gate at 0x104, sleep at 0x114
// R12: Enables change only while clock low
`include "clock_gate_bank_regs.svh"

module peripheral_clock_gate_bank
	import clock_gate_bank_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [`CGB_NUM_PERIPH-1:0] periph_access_i,
	output logic [`CGB_NUM_PERIPH-1:0] periph_fault_o,
	output logic [`CGB_NUM_PERIPH-1:0] periph_clk_o,
	output logic [`CGB_NUM_PERIPH-1:0] periph_clk_en_o,
	output logic irq_o
);

	apb_req_t req;
	logic [31:0] run_mode_clock_gate_group1;
	logic [31:0] sleep_mode_clock_gate_group1;
	logic [31:0] deep_sleep_clock_gate_group1;
	logic [31:0] mode_ctrl;
	logic [31:0] irq_status;
	logic [31:0] irq_mask;
	logic auto_gating_select;
	power_mode_t mode;
	logic [31:0] next_gate;
	periph_gate_t gate_fields;
	logic [`CGB_NUM_PERIPH-1:0] gate_vec;
	logic setup;
	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic [31:0] rd_mux;
	logic fault_event;
	logic slverr_event;
	logic [31:0] irq_set;
	logic [31:0] next_irq_status;
	logic irq_pending;
	logic [`CGB_NUM_PERIPH-1:0] gated_access;
	logic wr_run;
	logic wr_sleep;
	logic wr_deep;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_status;

	assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
		paddr: paddr_i, pwdata: pwdata_i};

	assign auto_gating_select = mode_ctrl[`CGB_CTRL_AUTO_GATING];

	// Deep sleep outranks sleep when software sets both
	always_comb begin
		if (mode_ctrl[`CGB_CTRL_DEEP_SLEEP]) begin
			mode = MODE_DEEP_SLEEP;
		end else if (mode_ctrl[`CGB_CTRL_SLEEP]) begin
			mode = MODE_SLEEP;
		end else begin
			mode = MODE_RUN;
		end
	end

	// Without auto gating the run register stays in force in every mode
	always_comb begin
		case (mode)
			MODE_RUN: next_gate = run_mode_clock_gate_group1; // R4
			MODE_SLEEP: next_gate = auto_gating_select ? sleep_mode_clock_gate_group1
				: run_mode_clock_gate_group1; // R5
			MODE_DEEP_SLEEP: next_gate = auto_gating_select ? deep_sleep_clock_gate_group1
				: run_mode_clock_gate_group1; // R5
			default: next_gate = run_mode_clock_gate_group1;
		endcase
	end

	always_comb begin
		gate_fields.gp_counter_c_clock_gate = next_gate[`CGB_BIT_COUNTER_C]; // R6
		gate_fields.gp_counter_b_clock_gate = next_gate[`CGB_BIT_COUNTER_B]; // R6
		gate_fields.gp_counter_a_clock_gate = next_gate[`CGB_BIT_COUNTER_A]; // R6
		gate_fields.two_wire_port_clock_gate = next_gate[`CGB_BIT_TWO_WIRE]; // R7
		gate_fields.sync_serial_clock_gate = next_gate[`CGB_BIT_SYNC_SERIAL]; // R8
		gate_fields.async_port_b_clock_gate = next_gate[`CGB_BIT_ASYNC_B]; // R9
		gate_fields.async_port_a_clock_gate = next_gate[`CGB_BIT_ASYNC_A]; // R9
	end

	// Vector order: [6] counter c .. [0] async port a
	assign gate_vec = gate_fields;

	// APB: one wait-free access phase, answer registered in the setup cycle
	assign setup = req.psel && !req.penable;

	// Only the offset is decoded; the fabric selects this block by its base
	always_comb begin
		case (req.paddr)
			`CGB_RUN_GATE_OFS,
			`CGB_SLEEP_GATE_OFS,
			`CGB_DEEP_GATE_OFS,
			`CGB_MODE_CTRL_OFS,
			`CGB_IRQ_STATUS_OFS,
			`CGB_IRQ_MASK_OFS: addr_hit = 1'b1; // R11
			default: addr_hit = 1'b0;
		endcase
	end

	assign wr_en = req.psel && req.penable && pready_o && req.pwrite && addr_hit;
	assign rd_en = setup && !req.pwrite;

	// One strobe per register, so each register process owns a single decode
	assign wr_run = wr_en && (req.paddr == `CGB_RUN_GATE_OFS); // R11
	assign wr_sleep = wr_en && (req.paddr == `CGB_SLEEP_GATE_OFS); // R11
	assign wr_deep = wr_en && (req.paddr == `CGB_DEEP_GATE_OFS);
	assign wr_ctrl = wr_en && (req.paddr == `CGB_MODE_CTRL_OFS);
	assign wr_mask = wr_en && (req.paddr == `CGB_IRQ_MASK_OFS);
	assign wr_status = wr_en && (req.paddr == `CGB_IRQ_STATUS_OFS);

	always_comb begin
		case (req.paddr)
			`CGB_RUN_GATE_OFS: rd_mux = run_mode_clock_gate_group1; // R11
			`CGB_SLEEP_GATE_OFS: rd_mux = sleep_mode_clock_gate_group1; // R11
			`CGB_DEEP_GATE_OFS: rd_mux = deep_sleep_clock_gate_group1;
			`CGB_MODE_CTRL_OFS: rd_mux = mode_ctrl;
			`CGB_IRQ_STATUS_OFS: rd_mux = irq_status;
			`CGB_IRQ_MASK_OFS: rd_mux = irq_mask;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Zero wait states: the answer always lands in the first access cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_o <= 1'b0;
		end else begin
			pready_o <= setup;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= slverr_event; // R11
		end
	end

	// Read data holds until the next setup; writes and misses read zero
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata_o <= rd_mux;
		end else if (setup) begin
			prdata_o <= 32'h0000_0000;
		end
	end

	// Reserved bits are masked off on write so they always read zero
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_mode_clock_gate_group1 <= `CGB_GATE_RESET; // R3
		end else if (wr_run) begin
			run_mode_clock_gate_group1 <= req.pwdata & `CGB_GATE_MASK; // R10
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sleep_mode_clock_gate_group1 <= `CGB_GATE_RESET; // R3
		end else if (wr_sleep) begin
			sleep_mode_clock_gate_group1 <= req.pwdata & `CGB_GATE_MASK; // R10
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			deep_sleep_clock_gate_group1 <= `CGB_GATE_RESET; // R3
		end else if (wr_deep) begin
			deep_sleep_clock_gate_group1 <= req.pwdata & `CGB_GATE_MASK; // R10
		end
	end

	// Mode bits reach the enables one edge after the write
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_ctrl <= 32'h0000_0000;
		end else if (wr_ctrl) begin
			mode_ctrl <= req.pwdata & `CGB_CTRL_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_mask <= 32'h0000_0000;
		end else if (wr_mask) begin
			irq_mask <= req.pwdata & `CGB_IRQ_MASK_BITS;
		end
	end

	// Registered enables feed the gate cells and are visible to the system
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			periph_clk_en_o <= '0; // R3
		end else begin
			periph_clk_en_o <= gate_vec; // R1
		end
	end

	// Fault answered one cycle after the access strobe while the gate is off
	assign gated_access = periph_access_i & ~periph_clk_en_o; // R2

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			periph_fault_o <= '0;
		end else begin
			periph_fault_o <= gated_access; // R2
		end
	end

	assign fault_event = |gated_access;
	assign slverr_event = setup && !addr_hit;

	always_comb begin
		irq_set = 32'h0000_0000;
		irq_set[`CGB_IRQ_FAULT] = fault_event;
		irq_set[`CGB_IRQ_SLVERR] = slverr_event;
	end

	// Write one to clear; a new event in the same cycle keeps its bit set
	always_comb begin
		next_irq_status = irq_status;
		if (wr_status) begin
			next_irq_status = irq_status & ~req.pwdata;
		end
		next_irq_status = (next_irq_status | irq_set) & `CGB_IRQ_MASK_BITS;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_status <= 32'h0000_0000;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// The mask only gates the output; status keeps recording while masked
	assign irq_pending = |(irq_status & irq_mask);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_pending;
		end
	end

	// Gate cells run from the retimed enables, so each switch is clean
	genvar g;
	generate
		for (g = 0; g < `CGB_NUM_PERIPH; g++) begin : gen_gate
			clock_gate_cell u_cell (
				.clk_i(clk_i),
				.arst_n_i(arst_n_i),
				.enable_i(periph_clk_en_o[g]),
				.gated_clk_o(periph_clk_o[g])
			); // R12
		end
	endgenerate

endmodule

/* File: hdl/clock_gate_bank_regs.svh */
// Register offsets, field positions, reset values and masks of the clock gate bank
`ifndef CLOCK_GATE_BANK_REGS_SVH
`define CLOCK_GATE_BANK_REGS_SVH

`define CGB_SYSCTL_BASE 32'h400F_E000
`define CGB_RUN_GATE_OFS 12'h104
`define CGB_SLEEP_GATE_OFS 12'h114
`define CGB_DEEP_GATE_OFS 12'h124
`define CGB_MODE_CTRL_OFS 12'h180
`define CGB_IRQ_STATUS_OFS 12'h184
`define CGB_IRQ_MASK_OFS 12'h188

`define CGB_GATE_RESET 32'h0000_0000
`define CGB_GATE_MASK 32'h0007_1013
`define CGB_CTRL_MASK 32'h0000_0007
`define CGB_IRQ_MASK_BITS 32'h0000_0003

`define CGB_BIT_COUNTER_C 18
`define CGB_BIT_COUNTER_B 17
`define CGB_BIT_COUNTER_A 16
`define CGB_BIT_TWO_WIRE 12
`define CGB_BIT_SYNC_SERIAL 4
`define CGB_BIT_ASYNC_B 1
`define CGB_BIT_ASYNC_A 0

`define CGB_CTRL_AUTO_GATING 0
`define CGB_CTRL_SLEEP 1
`define CGB_CTRL_DEEP_SLEEP 2

`define CGB_IRQ_FAULT 0
`define CGB_IRQ_SLVERR 1

`define CGB_NUM_PERIPH 7

`endif

/* File: hdl/clock_gate_bank_pkg.sv */
// Types shared by the clock gate bank
package clock_gate_bank_pkg;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_DEEP_SLEEP
	} power_mode_t;

	typedef struct packed {
		logic gp_counter_c_clock_gate;
		logic gp_counter_b_clock_gate;
		logic gp_counter_a_clock_gate;
		logic two_wire_port_clock_gate;
		logic sync_serial_clock_gate;
		logic async_port_b_clock_gate;
		logic async_port_a_clock_gate;
	} periph_gate_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

/* File: hdl/clock_gate_cell.sv */
// Glitch-free clock gate cell: enable latched while the source clock is low
module clock_gate_cell (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic enable_i,
	output logic gated_clk_o
);

	logic enable_ff;
	logic enable_low;

	// Enable retimed to the rising edge so it is stable across the low phase
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enable_ff <= 1'b0;
		end else begin
			enable_ff <= enable_i;
		end
	end

	// Transparent-low latch: the enable may only change while the clock is low
	always_latch begin
		if (!clk_i) begin
			enable_low = enable_ff; // R12
		end
	end

	assign gated_clk_o = clk_i & enable_low; // R1

endmodule

/* File: sim/clock_gate_bank_sva.sv */
// Port-level assertions for the clock gate bank
module clock_gate_bank_sva
	import clock_gate_bank_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [6:0] periph_access_i,
	input wire logic [6:0] periph_fault_o,
	input wire logic [6:0] periph_clk_o,
	input wire logic [6:0] periph_clk_en_o,
	input wire logic irq_o
);
	logic [2:0] ctrl;
	logic [6:0] lw;
	wire wr = psel_i && penable_i && pwrite_i && pready_o;
	// Shadow of mode control and last written gate map
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl <= 3'h0;
			lw <= 7'h00;
		end else if (wr) begin
			lw <= {pwdata_i[18:16], pwdata_i[12], pwdata_i[4], pwdata_i[1:0]};
			if (paddr_i == 12'h180) begin
				ctrl <= pwdata_i[2:0];
			end
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_run;
		wr && paddr_i == 12'h104 && !ctrl[0];
	endsequence
	sequence s_slp;
		wr && paddr_i == 12'h114;
	endsequence
	property p_cnt;
		s_run |-> ##2 periph_clk_en_o[6:4] == lw[6:4];
	endproperty
	a_cnt: assert property (p_cnt) else $error("counter gates");
	property p_tw;
		s_run |-> ##2 periph_clk_en_o[3] == lw[3];
	endproperty
	a_tw: assert property (p_tw) else $error("two-wire gate");
	property p_ss;
		s_run |-> ##2 periph_clk_en_o[2] == lw[2];
	endproperty
	a_ss: assert property (p_ss) else $error("sync gate");
	property p_as;
		s_run |-> ##2 periph_clk_en_o[1:0] == lw[1:0];
	endproperty
	a_as: assert property (p_as) else $error("async gates");
	property p_slp_off;
		s_slp ##0 !ctrl[0] |-> ##2 $stable(periph_clk_en_o);
	endproperty
	a_slp_off: assert property (p_slp_off) else $error("sleep gate leaked");
	property p_slp_on;
		s_slp ##0 ctrl == 3'h3 |-> ##2 periph_clk_en_o == lw;
	endproperty
	a_slp_on: assert property (p_slp_on) else $error("sleep gate unused");
	property p_rsv;
		pready_o && !pwrite_i && paddr_i == 12'h104 |-> prdata_o[31:19] == 13'h0000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_flt;
		|periph_access_i |=> periph_fault_o == $past(periph_access_i & ~periph_clk_en_o);
	endproperty
	a_flt: assert property (p_flt) else $error("fault wrong");
endmodule

/* File: sim/periph_model.sv */
// Peripheral side: counts the clock edges each unit receives
module periph_model
	import clock_gate_bank_pkg::*;
(
	input wire logic arst_n_i,
	input wire logic [6:0] gclk_i,
	output wire logic [6:0][15:0] ticks_o
);
	timeunit 1ns;
	timeprecision 1ps;
	for (genvar i = 0; i < 7; i++) begin : g_unit
		logic [15:0] cnt;
		always_ff @(posedge gclk_i[i] or negedge arst_n_i) begin
			if (!arst_n_i) begin
				cnt <= 16'h0000;
			end else begin
				cnt <= cnt + 16'h0001;
			end
		end
		assign ticks_o[i] = cnt;
	end
endmodule

/* File: sim/peripheral_clock_gate_bank_bench.sv */
// Self-checking bench for the peripheral clock gate bank
module peripheral_clock_gate_bank_bench import clock_gate_bank_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic irq_o, pready_o, pslverr_o, err;
	logic [11:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0, prdata_o, rd;
	logic [6:0] periph_access_i = '0, periph_fault_o, periph_clk_o, periph_clk_en_o;
	wire [6:0][15:0] ticks;
	logic [6:0][15:0] t0;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	int pos[7] = '{0, 1, 4, 12, 16, 17, 18};
	logic [2:0] mode[5] = '{3'h2, 3'h3, 3'h7, 3'h4, 3'h0};
	logic [6:0] men[5] = '{7'h04, 7'h01, 7'h02, 7'h04, 7'h04};
	peripheral_clock_gate_bank u_dut (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .periph_access_i,
		.periph_fault_o, .periph_clk_o, .periph_clk_en_o, .irq_o);
	periph_model u_periph (.arst_n_i, .gclk_i(periph_clk_o), .ticks_o(ticks));
	always #4 clk_i = ~clk_i;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'h1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clk_i);
	endtask
	// Enables, then clock edges seen by each unit over four cycles
	task automatic chk_en(input logic [6:0] exp);
		@(posedge clk_i);
		#1;
		check(periph_clk_en_o, exp);
		t0 = ticks;
		repeat (4) @(posedge clk_i);
		#1;
		for (int j = 0; j < 7; j++) begin
			check(ticks[j] - t0[j], exp[j] ? 32'h0000_0004 : 32'h0000_0000);
		end
		@(posedge clk_i);
	endtask
	task automatic chk_irq(input logic exp);
		@(posedge clk_i);
		#1;
		check(irq_o, exp);
		@(posedge clk_i);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			results();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		arst_n_i <= 1'h1;
		@(posedge clk_i);
		apb(1'h0, 12'h104, '0);
		check(rd, 32'h0000_0000);
		apb(1'h0, 12'h114, '0);
		check(rd, 32'h0000_0000);
		apb(1'h1, 12'h104, 32'hffff_ffff);
		check(err, 1'h0);
		apb(1'h0, 12'h104, '0);
		check(rd, 32'h0007_1013);
		chk_en(7'h7f);
		apb(1'h0, 12'h200, '0);
		check(err, 1'h1);
		check(rd, 32'h0000_0000);
		$display("registers done");
		// Walking single gate, then strobe every unit
		for (int i = 0; i < 7; i++) begin
			apb(1'h1, 12'h104, 32'h0000_0001 << pos[i]);
			chk_en(7'h01 << i);
			periph_access_i <= 7'h7f;
			@(posedge clk_i);
			periph_access_i <= 7'h00;
			#1;
			check(periph_fault_o, {25'h0, ~(7'h01 << i)});
			@(posedge clk_i);
		end
		$display("gates done");
		apb(1'h1, 12'h114, 32'h0000_0001);
		apb(1'h1, 12'h124, 32'h0000_0002);
		apb(1'h1, 12'h104, 32'h0000_0010);
		for (int m = 0; m < 5; m++) begin
			apb(1'h1, 12'h180, {29'h0, mode[m]});
			chk_en(men[m]);
		end
		apb(1'h1, 12'h180, 32'h0000_0003);
		apb(1'h1, 12'h114, 32'h0004_0000);
		chk_en(7'h40);
		apb(1'h1, 12'h180, 32'h0000_0000);
		apb(1'h0, 12'h104, '0);
		apb(1'h1, 12'h104, rd | 32'h0000_0001);
		chk_en(7'h05);
		$display("modes done");
		chk_irq(1'h0);
		apb(1'h1, 12'h188, 32'h0000_0001);
		chk_irq(1'h1);
		apb(1'h0, 12'h184, '0);
		check(rd, 32'h0000_0003);
		apb(1'h1, 12'h184, 32'h0000_0003);
		chk_irq(1'h0);
		apb(1'h0, 12'h184, '0);
		check(rd, 32'h0000_0000);
		$display("interrupt done");
		// Reset in mid-run must clear gates that software had set
		arst_n_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1'h1;
		@(posedge clk_i);
		apb(1'h0, 12'h104, '0);
		check(rd, 32'h0000_0000);
		chk_en(7'h00);
		$display("reset done");
		results();
	end
endmodule
bind peripheral_clock_gate_bank clock_gate_bank_sva u_sva (.clk_i, .arst_n_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
	.periph_access_i, .periph_fault_o, .periph_clk_o, .periph_clk_en_o, .irq_o);
